// File: rtl/sps_core.sv
// Serial peripheral status flags, data path and shift engine.
// Assumes a classic Wishbone master and a peer serial device on the pins.
// Operation
// RULE1: Set done flag when any exchange finishes.
// RULE2: Raise interrupt when done flag set, enabled.
// RULE3: Clear done: status read, then data access.
// RULE4: Ignore data writes until status read sees done.
// RULE5: Busy write sets collision flag, is discarded.
// RULE6: Phase zero: busy from select fall to rise.
// RULE7: Phase one: busy first edge until done.
// RULE8: Clear collision: status read, then data access.
// RULE9: Mode fault only as master, select driven low.
// RULE10: Mode fault raises interrupt when enabled.
// RULE11: Mode fault clears enable and master bits.
// RULE12: Clear fault: status read, then control write.
// RULE13: Software may restore enable and master bits.
// RULE14: Software reprograms port D direction after fault.
// RULE15: Unimplemented status bits read as zero.
// RULE16: Only master data write starts an exchange.
// RULE17: Data reads return receive buffer, not shifter.
// RULE18: Overrun keeps old buffer, drops new byte.
// RULE19: Data write loads shift register directly.
// RULE20: Master emits eight clocks then idles clock.
// RULE21: Eight bits shifted copy into receive buffer.
// RULE22: Done bit7, collision bit6, fault bit4.
// RULE23: Reset clears all three status flags.
//
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module sps_core (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  input wire logic ss_b_i,
  output logic irq_o
);
  // Register state.
  logic [7:0] ctrl_reg;
  logic [7:0] shreg_reg;
  logic [7:0] rxbuf_reg;
  logic done_reg, write_collision_flag_reg, fault_reg;
  logic done_arm_reg, write_collision_flag_arm_reg, fault_arm_reg;
  logic lock_reg;
  // Serial engine state.
  sps_pkg::sps_mst_t mst_reg;
  logic [4:0] half_cnt_reg;
  logic [3:0] half_idx_reg;
  logic [3:0] bit_cnt_reg;
  logic sbusy_reg;
  logic out_bit_reg;
  logic sck_d_reg, ss_d_reg;
  logic [3:0] pins_s;
  // All pins cross into mclk through the filtered synchroniser.
  sps_sync3 #(.WIDTH(4), .RST_VAL(sps_pkg::PIN_RST)) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .d_in({sck_i, ss_b_i, mosi_i, miso_i}),
    .q_out(pins_s)
  );
  // Named views of the synchronised pins and control bits.
  wire sck_s = pins_s[3];
  wire ss_s = pins_s[2];
  wire mosi_s = pins_s[1];
  wire miso_s = pins_s[0];
  wire irq_en = ctrl_reg[sps_pkg::CTL_IRQ_EN];
  wire sys_en = ctrl_reg[sps_pkg::CTL_SYS_EN];
  wire master = ctrl_reg[sps_pkg::CTL_MASTER];
  wire cpol = ctrl_reg[sps_pkg::CTL_CPOL];
  wire clock_phase_select = ctrl_reg[sps_pkg::CTL_CLOCK_PHASE_SELECT];
  wire run = (mst_reg == sps_pkg::MST_RUN);
  // Bus decode; effects take place at the edge where ack is seen high.
  wire req = wb_cyc_i & wb_stb_i;
  wire acc = req & wb_ack_o;
  wire [3:0] adr_w = {wb_adr_i[3:2], 2'b00};
  wire sel_ctrl = (adr_w == sps_pkg::ADR_CTRL);
  wire sel_stat = (adr_w == sps_pkg::ADR_STAT);
  wire sel_data = (adr_w == sps_pkg::ADR_DATA);
  wire wr_acc = acc & wb_we_i & wb_sel_i[0];
  wire rd_acc = acc & ~wb_we_i;
  wire ctrl_wr = wr_acc & sel_ctrl;
  wire stat_rd = rd_acc & sel_stat;
  wire dwr = wr_acc & sel_data;
  wire daccess = (wr_acc | rd_acc) & sel_data;
  // Status image with unimplemented bits tied low.
  wire [7:0] stat_w = {done_reg, write_collision_flag_reg, 1'b0, fault_reg, 4'h0}; // RULE15 RULE22
  // Data reads see the receive buffer, never the live shifter.
  wire [7:0] rdata_w = sel_ctrl ? ctrl_reg :
                       sel_stat ? stat_w :
                       sel_data ? rxbuf_reg : 8'h00; // RULE17
  // Status-read observations use the value actually returned to software.
  wire saw_done = stat_rd & wb_dat_o[sps_pkg::STAT_DONE];
  wire saw_write_collision_flag = stat_rd & wb_dat_o[sps_pkg::STAT_WRITE_COLLISION_FLAG];
  wire saw_fault = stat_rd & wb_dat_o[sps_pkg::STAT_FAULT];
  // Serial clock edges from the peer, found on the synchronised level.
  wire s_edge = sck_s ^ sck_d_reg;
  wire s_lead = s_edge & (sck_d_reg == cpol);
  wire s_trail = s_edge & (sck_d_reg != cpol);
  wire slave_sel = sys_en & ~master & ~ss_s;
  wire ss_fall = ss_d_reg & ~ss_s;
  wire ss_rise = ~ss_d_reg & ss_s;
  // Master half-period divider, enabled only while shifting.
  // Limitation: miso crosses the pin synchroniser, so only the two slowest rates capture reliably.
  wire [4:0] half_lim = (ctrl_reg[1:0] == 2'b00) ? sps_pkg::HALF_DIV0 :
                        (ctrl_reg[1:0] == 2'b01) ? sps_pkg::HALF_DIV1 :
                        (ctrl_reg[1:0] == 2'b10) ? sps_pkg::HALF_DIV2 : sps_pkg::HALF_DIV3;
  wire half_tick = run & (half_cnt_reg == half_lim - 5'h01);
  wire m_lead = half_tick & ~half_idx_reg[0];
  wire m_trail = half_tick & half_idx_reg[0];
  // Capture and launch edges chosen by phase and by role.
  wire lead = master ? m_lead : (s_lead & slave_sel);
  wire trail = master ? m_trail : (s_trail & slave_sel);
  wire cap = clock_phase_select ? trail : lead;
  wire launch = clock_phase_select ? lead : trail;
  wire din = master ? miso_s : mosi_s;
  wire [7:0] shift_w = {shreg_reg[6:0], din};
  // Completion of a byte exchange in either role.
  wire m_done = half_tick & (half_idx_reg == sps_pkg::HALF_LAST);
  wire s_done = cap & ~master & (bit_cnt_reg == sps_pkg::BITS_LAST);
  wire complete = m_done | s_done; // RULE1
  wire [7:0] rxbyte_w = cap ? shift_w : shreg_reg;
  // Transfer in progress, as the collision check defines it.
  wire xfer_busy = run | sbusy_reg;
  wire write_ok = dwr & ~lock_reg; // RULE4
  wire collide = write_ok & xfer_busy; // RULE5
  wire load = write_ok & ~xfer_busy; // RULE19
  wire start = load & master & sys_en; // RULE16
  wire fault_set = master & sys_en & ~ss_s; // RULE9
  // Flag next values; a set in the same cycle beats a clear.
  wire done_next = complete | (done_reg & ~(daccess & done_arm_reg)); // RULE1 RULE3
  wire write_collision_flag_next = collide | (write_collision_flag_reg & ~(daccess & write_collision_flag_arm_reg)); // RULE5 RULE8
  wire fault_next = fault_set | (fault_reg & ~(ctrl_wr & fault_arm_reg)); // RULE12
  // Bus slave: ack one cycle after the request, dropped the cycle after.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      if (req & ~wb_ack_o) begin
        wb_dat_o <= {24'h00_0000, rdata_w};
      end
    end
  end

  // Control register; a mode fault forces enable and master low.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= sps_pkg::CTRL_RST;
    end else begin
      if (ctrl_wr) begin
        ctrl_reg <= wb_dat_i[7:0];
      end
      if (fault_set) begin
        ctrl_reg[sps_pkg::CTL_SYS_EN] <= 1'b0; // RULE11
        ctrl_reg[sps_pkg::CTL_MASTER] <= 1'b0; // RULE11
      end
    end
  end

  // Status flags, clearing sequences and the write lock.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      done_reg <= 1'b0; // RULE23
      write_collision_flag_reg <= 1'b0; // RULE23
      fault_reg <= 1'b0; // RULE23
      done_arm_reg <= 1'b0;
      write_collision_flag_arm_reg <= 1'b0;
      fault_arm_reg <= 1'b0;
      lock_reg <= 1'b0;
    end else begin
      done_reg <= done_next;
      write_collision_flag_reg <= write_collision_flag_next;
      fault_reg <= fault_next;
      // Arming needs a status read that returned the flag set.
      done_arm_reg <= saw_done | (done_arm_reg & ~daccess); // RULE3
      write_collision_flag_arm_reg <= saw_write_collision_flag | (write_collision_flag_arm_reg & ~daccess); // RULE8
      fault_arm_reg <= saw_fault | (fault_arm_reg & ~ctrl_wr); // RULE12
      // The lock follows each completion; the sighting read lifts it.
      lock_reg <= complete | (lock_reg & ~saw_done); // RULE4
    end
  end

  // Interrupt request for a finished exchange or a mode fault.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_en & (done_reg | fault_reg); // RULE2 RULE10
    end
  end

  // Master sequencer: sixteen half periods, then the clock idles.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mst_reg <= sps_pkg::MST_IDLE;
      half_cnt_reg <= 5'h00;
      half_idx_reg <= 4'h0;
    end else begin
      unique case (mst_reg)
        sps_pkg::MST_IDLE: begin
          half_cnt_reg <= 5'h00;
          half_idx_reg <= 4'h0;
          if (start) begin
            mst_reg <= sps_pkg::MST_RUN; // RULE16 RULE20
          end
        end
        sps_pkg::MST_RUN: begin
          // A fault aborts the byte; the peer now owns the bus.
          if (m_done | fault_set) begin
            mst_reg <= sps_pkg::MST_IDLE; // RULE20
          end
          if (half_tick) begin
            half_cnt_reg <= 5'h00;
            half_idx_reg <= half_idx_reg + 4'h1;
          end else begin
            half_cnt_reg <= half_cnt_reg + 5'h01;
          end
        end
      endcase
    end
  end

  // Slave busy window and capture count.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sbusy_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
      sck_d_reg <= 1'b0;
      ss_d_reg <= 1'b1;
    end else begin
      sck_d_reg <= sck_s;
      ss_d_reg <= ss_s;
      if (!clock_phase_select && ss_fall && sys_en && !master) begin
        sbusy_reg <= 1'b1; // RULE6
      end else if (clock_phase_select && s_lead && slave_sel) begin
        sbusy_reg <= 1'b1; // RULE7
      end else if (clock_phase_select && s_done) begin
        sbusy_reg <= 1'b0; // RULE7
      end else if (ss_rise || master || !sys_en) begin
        sbusy_reg <= 1'b0; // RULE6
      end
      // Count restarts per byte; a deselect also resets it.
      if (ss_s || master || s_done) begin
        bit_cnt_reg <= 4'h0;
      end else if (cap) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
    end
  end

  // Shift register, output bit and receive buffer.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      shreg_reg <= sps_pkg::DATA_RST;
      rxbuf_reg <= sps_pkg::DATA_RST;
      out_bit_reg <= 1'b0;
    end else begin
      if (load) begin
        shreg_reg <= wb_dat_i[7:0]; // RULE19
      end else if (cap) begin
        shreg_reg <= shift_w;
      end
      // Phase zero puts the first bit out before any clock edge.
      if (load && !clock_phase_select) begin
        out_bit_reg <= wb_dat_i[7];
      end else if (ss_fall && !clock_phase_select && !master) begin
        out_bit_reg <= shreg_reg[7];
      end else if (launch) begin
        out_bit_reg <= shreg_reg[7];
      end
      // An unread previous byte wins: the new one is dropped.
      if (complete && !done_reg) begin
        rxbuf_reg <= rxbyte_w; // RULE18 RULE21
      end
    end
  end

  // Pin drivers, all registered.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sck_o <= 1'b0;
      sck_oe <= 1'b0;
      mosi_o <= 1'b0;
      mosi_oe <= 1'b0;
      miso_o <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      sck_o <= run ? (cpol ^ half_idx_reg[0] ^ half_tick) : cpol; // RULE20
      sck_oe <= master & sys_en;
      mosi_o <= out_bit_reg;
      mosi_oe <= master & sys_en;
      miso_o <= out_bit_reg;
      miso_oe <= slave_sel;
    end
  end

  // Checks.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  property p_done_set;
    complete |=> done_reg;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag missed"); // RULE1
  property p_irq;
    (done_reg && irq_en) ##1 (done_reg && irq_en) |-> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("no interrupt for done"); // RULE2
  property p_done_hold;
    done_reg && !done_arm_reg && !saw_done |=> done_reg;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done cleared early"); // RULE3
  // A slave capture may still shift in the same cycle, so that case is left out.
  property p_lock;
    lock_reg && dwr && !run && !cap |=> !run && $stable(shreg_reg);
  endproperty
  a_lock: assert property (p_lock) else $error("locked write took effect"); // RULE4
  // A byte that ends or aborts in the same cycle legally stops the run.
  property p_write_collision_flag;
    dwr && !lock_reg && run && !m_done && !fault_set |=> write_collision_flag_reg && run;
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged"); // RULE5
  property p_fault;
    master && sys_en && !ss_s |=> fault_reg && !master && !sys_en;
  endproperty
  a_fault: assert property (p_fault) else $error("mode fault handling wrong"); // RULE9
  property p_fault_src;
    !fault_reg && !(master && sys_en) |=> !fault_reg;
  endproperty
  a_fault_src: assert property (p_fault_src) else $error("fault set outside master"); // RULE9
  property p_stat_zero;
    wb_ack_o && !wb_we_i && sel_stat |-> (wb_dat_o[5] == 1'b0) && (wb_dat_o[3:0] == 4'h0);
  endproperty
  a_stat_zero: assert property (p_stat_zero) else $error("reserved status bit set"); // RULE15
  property p_start;
    $rose(run) |-> $past(dwr) && $past(master);
  endproperty
  a_start: assert property (p_start) else $error("exchange started without master write"); // RULE16
  property p_overrun;
    complete && done_reg |=> $stable(rxbuf_reg);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun overwrote buffer"); // RULE18
  property p_run_len;
    $rose(run) |-> run [*8] ##[1:600] !run;
  endproperty
  a_run_len: assert property (p_run_len) else $error("master byte length wrong"); // RULE20
  c_master: cover property (m_done);
  c_slave: cover property (s_done);
  c_overrun: cover property (complete && done_reg);
  c_fault: cover property (fault_set);
endmodule : sps_core
`default_nettype wire

// File: rtl/sps_pkg.sv
// Constants for the serial status and data path block.
// Assumes a classic Wishbone register bus and one core clock.
package sps_pkg;
  // Register byte addresses on the bus.
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_STAT = 4'h4;
  localparam logic [3:0] ADR_DATA = 4'h8;
  // Control register field positions.
  localparam int CTL_IRQ_EN = 7;
  localparam int CTL_SYS_EN = 6;
  localparam int CTL_MASTER = 4;
  localparam int CTL_CPOL = 3;
  localparam int CTL_CLOCK_PHASE_SELECT = 2;
  // Status register field positions.
  localparam int STAT_DONE = 7;
  localparam int STAT_WRITE_COLLISION_FLAG = 6;
  localparam int STAT_FAULT = 4;
  // Reset values.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  // Half serial clock periods in core cycles for rates 2, 4, 16 and 32.
  localparam logic [4:0] HALF_DIV0 = 5'h01;
  localparam logic [4:0] HALF_DIV1 = 5'h02;
  localparam logic [4:0] HALF_DIV2 = 5'h08;
  localparam logic [4:0] HALF_DIV3 = 5'h10;
  // Bit count at the last bit of one byte exchange and the last half period index.
  localparam logic [3:0] BITS_LAST = 4'h7;
  localparam logic [3:0] HALF_LAST = 4'hf;
  // Reset value of the synchronised pins: sck, slave select, mosi, miso.
  localparam logic [3:0] PIN_RST = 4'h4;
  // Master sequencer states.
  typedef enum logic [0:0] {MST_IDLE = 1'b0, MST_RUN = 1'b1} sps_mst_t;
endpackage : sps_pkg

// File: rtl/sps_sync3.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes inputs are asynchronous to mclk.
`timescale 1ns/10ps
`default_nettype none
module sps_sync3 #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  // Stage one is read only by stage two, to contain metastability.
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  // A bit changes only once stages two and three agree on it.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      q_out <= RST_VAL;
    end else begin
      s1_reg <= d_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_out <= (s2_reg & s3_reg) | (q_out & (s2_reg ^ s3_reg));
    end
  end
endmodule : sps_sync3
`default_nettype wire

// File: tb/sps_peer.sv
// Peer serial device model for the status and data path bench.
// Assumes it is a mode 0 slave, or a mode 1 master with a 160 ns clock.
`timescale 1ns/10ps
`default_nettype none
module sps_peer (
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic miso_i,
  output logic sck_o,
  output logic mosi_o,
  output logic mosi_oe,
  output logic miso_o,
  output logic miso_oe,
  output logic ss_b_o
);
  logic [7:0] stx_reg; // Byte the slave side returns.
  logic [7:0] srx_reg; // Byte the slave side captured.
  logic [7:0] mrx_reg; // Byte the master side captured.
  // The clock stands still at the idle level outside frames.
  initial begin
    sck_o = 1'b0;
    mosi_o = 1'b0;
    mosi_oe = 1'b0;
    miso_oe = 1'b0;
    ss_b_o = 1'b1;
  end
  assign miso_o = stx_reg[7];
  // Slave side samples on the rising edge and shifts on the falling one.
  always @(posedge sck_i) if (miso_oe) srx_reg <= {srx_reg[6:0], mosi_i};
  // Shifting in the inverse keeps the line moving after the last bit.
  always @(negedge sck_i) if (miso_oe) stx_reg <= {stx_reg[6:0], ~stx_reg[0]};
  task slave_load(input logic [7:0] b);
    stx_reg = b;
    miso_oe = 1'b1;
  endtask : slave_load
  task slave_off;
    miso_oe = 1'b0;
  endtask : slave_off
  // Drives the select line alone, with no clock, to frame a phase zero transfer.
  task select_line(input logic lvl);
    ss_b_o = lvl;
  endtask : select_line
  // Mode 1 frame: data goes out on the leading edge, is captured on the trailing one.
  task master_xfer(input logic [7:0] b);
    integer i;
    #7.3 ss_b_o = 1'b0;
    mosi_oe = 1'b1;
    #80;
    for (i = 7; i >= 0; i--) begin
      sck_o = 1'b1;
      mosi_o = b[i];
      #80 sck_o = 1'b0;
      mrx_reg = {mrx_reg[6:0], miso_i};
      #80;
    end
    ss_b_o = 1'b1;
    mosi_oe = 1'b0;
  endtask : master_xfer
  // A second master pulls select low while the device is master.
  task fault_pulse;
    ss_b_o = 1'b0;
    #200 ss_b_o = 1'b1;
  endtask : fault_pulse
endmodule : sps_peer
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the serial status and data path block.
// Assumes the design files and the peer model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, flt = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000, rnd;
  wire logic [31:0] wb_dat_o;
  wire logic wb_ack_o, irq_o, dsck, dsck_oe, dmosi, dmosi_oe, dmiso, dmiso_oe;
  wire logic psck, pmosi, pmosi_oe, pmiso, pmiso_oe, pss_b;
  integer failures = 0, n_tests = 0, cycles = 0, seed = 32'hcd67;
  logic [7:0] exp_q[$]; // Expected read data, oldest first.
  logic [7:0] t1, t2, t3, t4, t5, t6, r1, r2, r3, m1, m2;
  // Undriven data lines toggle so a stale level never passes.
  wire logic sck_w = dsck_oe ? dsck : psck;
  wire logic mosi_w = dmosi_oe ? dmosi : (pmosi_oe ? pmosi : flt);
  wire logic miso_w = dmiso_oe ? dmiso : (pmiso_oe ? pmiso : flt);
  sps_core dut (.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sck_i(sck_w), .sck_o(dsck), .sck_oe(dsck_oe), .mosi_i(mosi_w), .mosi_o(dmosi),
    .mosi_oe(dmosi_oe), .miso_i(miso_w), .miso_o(dmiso), .miso_oe(dmiso_oe), .ss_b_i(pss_b),
    .irq_o(irq_o));
  sps_peer peer (.sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w), .sck_o(psck), .mosi_o(pmosi),
    .mosi_oe(pmosi_oe), .miso_o(pmiso), .miso_oe(pmiso_oe), .ss_b_o(pss_b));
  always #2 mclk = ~mclk;
  always @(posedge mclk) flt <= ~flt;
  // A hang counts as a mismatch and ends the run.
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      results();
    end
  end
  // Read results are compared against the oldest expectation when ack shows.
  always @(posedge mclk) begin
    if (wb_ack_o === 1'b1 && we === 1'b0) begin
      n_tests = n_tests + 1;
      if (wb_dat_o !== {{24{1'b0}}, exp_q[0]}) begin
        failures = failures + 1;
        $display("CHECK FAILED at %0t: read %h expected %h", $time, wb_dat_o, exp_q[0]);
      end
      void'(exp_q.pop_front());
    end
  end
  // One classic cycle; the request holds until ack is sampled high.
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    rnd = $random(seed);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {rnd[31:8], d};
    sel <= {rnd[3:1], 1'b1};
    @(posedge mclk);
    while (wb_ack_o !== 1'b1) @(posedge mclk);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask : rd
  task chk(input logic c, input string m);
    n_tests = n_tests + 1;
    if (c !== 1'b1) begin
      failures = failures + 1;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk
  task wirq;
    integer k;
    k = 0;
    while (irq_o !== 1'b1 && k < 3000) begin
      @(posedge mclk);
      k = k + 1;
    end
    chk(k < 3000, "no completion");
  endtask : wirq
  task results;
    $display("failures %0d n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results
  initial begin
    {t1, t2, t3, t4} = $random(seed);
    {t5, t6, r1, r2} = $random(seed);
    {r3, m1, m2} = 24'($random(seed));
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    // Reset values, reserved bits and an unmapped place.
    rd(sps_pkg::ADR_STAT, 8'h00);
    rd(sps_pkg::ADR_CTRL, 8'h00);
    bus(1'b1, 4'hc, t1);
    rd(4'hc, 8'h00);
    // Master exchange with a collision, then the clearing sequence.
    peer.slave_load(r1);
    // The slowest rate leaves room for the pin synchroniser on received bits.
    bus(1'b1, sps_pkg::ADR_CTRL, 8'hd3);
    bus(1'b1, sps_pkg::ADR_DATA, t1);
    bus(1'b1, sps_pkg::ADR_DATA, t2);
    wirq();
    chk(peer.srx_reg === t1 && sck_w === 1'b0, "master byte");
    rd(sps_pkg::ADR_STAT, 8'hc0);
    rd(sps_pkg::ADR_DATA, r1);
    rd(sps_pkg::ADR_STAT, 8'h00);
    chk(irq_o === 1'b0, "irq stuck");
    // Writes are locked after a completion until status shows done.
    peer.slave_load(r2);
    bus(1'b1, sps_pkg::ADR_DATA, t3);
    wirq();
    rd(sps_pkg::ADR_DATA, r2);
    bus(1'b1, sps_pkg::ADR_DATA, t4);
    repeat (100) @(posedge mclk);
    chk(peer.srx_reg === t3, "locked write sent");
    rd(sps_pkg::ADR_STAT, 8'h80);
    peer.slave_load(r3);
    bus(1'b1, sps_pkg::ADR_DATA, t5);
    repeat (3) @(posedge mclk);
    wirq();
    chk(peer.srx_reg === t5, "unlocked write");
    // Slave exchanges in phase one, the second one overruns.
    peer.slave_off();
    bus(1'b1, sps_pkg::ADR_CTRL, 8'hc4);
    rd(sps_pkg::ADR_STAT, 8'h80);
    rd(sps_pkg::ADR_DATA, r3);
    rd(sps_pkg::ADR_STAT, 8'h00);
    bus(1'b1, sps_pkg::ADR_DATA, t6);
    repeat (50) @(posedge mclk);
    chk(dsck_oe === 1'b0 && irq_o === 1'b0, "slave started");
    peer.master_xfer(m1);
    repeat (10) @(posedge mclk);
    chk(irq_o === 1'b1 && peer.mrx_reg === t6, "slave byte");
    peer.master_xfer(m2);
    repeat (10) @(posedge mclk);
    rd(sps_pkg::ADR_STAT, 8'h80);
    rd(sps_pkg::ADR_DATA, m1);
    rd(sps_pkg::ADR_STAT, 8'h00);
    // Mode fault as master, then clearing and restoring control.
    bus(1'b1, sps_pkg::ADR_CTRL, 8'hd0);
    peer.fault_pulse();
    repeat (10) @(posedge mclk);
    chk(irq_o === 1'b1, "fault irq");
    rd(sps_pkg::ADR_STAT, 8'h10);
    rd(sps_pkg::ADR_CTRL, 8'h80);
    bus(1'b1, sps_pkg::ADR_CTRL, 8'hd0);
    rd(sps_pkg::ADR_STAT, 8'h00);
    rd(sps_pkg::ADR_CTRL, 8'hd0);
    chk(irq_o === 1'b0, "fault irq stuck");
    // Phase zero slave: a low select alone marks a transfer, so a data write collides.
    bus(1'b1, sps_pkg::ADR_CTRL, 8'hc0);
    peer.select_line(1'b0);
    repeat (10) @(posedge mclk);
    bus(1'b1, sps_pkg::ADR_DATA, t2);
    rd(sps_pkg::ADR_STAT, 8'h40);
    peer.select_line(1'b1);
    repeat (10) @(posedge mclk);
    bus(1'b1, sps_pkg::ADR_DATA, t3);
    rd(sps_pkg::ADR_STAT, 8'h00);
    results();
  end
endmodule : testbench
`default_nettype wire
